// *** adc_conversion_control_test.sv ***
// Self-checking testbench of the converter control block.
`timescale 1ns/100ps
module adc_conversion_control_test import adcc_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic awvalid = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic wvalid = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic [ADDR_W-1:0] araddr = '0;
  logic rready = 1'b0;
  logic conv_done = 1'b0;
  logic [RESULT_W-1:0] conv_data = '0;
  logic dma_done = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] gain_exp;
  adcc_conv_s conv_ctl;
  logic [33:0] exp_q[$];
  int error_cnt = 0;
  int n_checks = 0;
  int start_cnt = 0;
  int seed = 8739;

  adcc_top i_adcc_top (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .conv_ctl(conv_ctl), .gain_exp(gain_exp), .conv_done(conv_done),
    .conv_data(conv_data), .dma_done(dma_done), .irq(irq)
  );

  always #5 aclk = ~aclk;

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Bus results are compared in the order the requests were issued.
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) begin
      chk({bresp, 32'h0}, exp_q.pop_front());
    end
    if (rvalid === 1'b1 && rready) begin
      chk({rresp, rdata}, exp_q.pop_front());
    end
    if (aresetn && conv_ctl.start === 1'b1) begin
      start_cnt++;
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_t;
    logic w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw_t = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_t = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // The converter pulses last one cycle; data is scrambled once it is no longer valid.
  task automatic pulse(input logic c, input logic m, input logic [11:0] d);
    @(posedge aclk);
    conv_done <= c;
    dma_done <= m;
    conv_data <= d;
    @(posedge aclk);
    conv_done <= 1'b0;
    dma_done <= 1'b0;
    conv_data <= ~d;
  endtask

  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    logic [7:0] ra [7];
    logic [3:0] ge;
    logic [11:0] d;
    ra = '{OFS_CONV_CTRL, OFS_PROBE_CTRL, OFS_RESULT, OFS_CONFIG, OFS_IRQ_STAT,
           OFS_IRQ_MASK, OFS_FLAG};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk(34'(conv_ctl.gain_sel), 34'(3'b010));
    chk(34'({conv_ctl.run, conv_ctl.probe_pwr}), 34'h0);
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], (ra[i] == OFS_CONFIG) ? 32'h2 : 32'h0, RESP_OKAY);
    end
    rd(8'h1c, 32'h0, RESP_SLVERR);
    wr(8'h1c, 32'hffff_ffff, RESP_SLVERR);
    wr(OFS_PROBE_CTRL, 32'h80, RESP_OKAY);
    rd(OFS_PROBE_CTRL, 32'h80, RESP_OKAY);
    settle();
    chk(34'(conv_ctl.probe_pwr), 34'h1);
    wr(OFS_PROBE_CTRL, 32'h0, RESP_OKAY);
    settle();
    chk(34'(conv_ctl.probe_pwr), 34'h0);
    // Every direction and code, with the buffer bit held on and the differential bit moving as well.
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CONFIG, 32'(i[1:0]) | 32'h4 | (32'(i[0]) << 3), RESP_OKAY);
      wr(OFS_CONV_CTRL, 32'(i[2]) << 1, RESP_OKAY);
      rd(OFS_CONV_CTRL, 32'(i[2]) << 1, RESP_OKAY);
      settle();
      ge = i[2] ? 4'(i[1:0]) + 4'h1 : 4'(i[1:0]) - 4'h2;
      chk(34'(conv_ctl.gain_sel), 34'(i[2:0]));
      chk(34'(gain_exp), 34'(ge));
      chk(34'({conv_ctl.buf_on, conv_ctl.diff}), 34'({1'b1, i[0]}));
    end
    // Probe conversions keep the direction bit low so the selection reads 011b.
    wr(OFS_CONFIG, 32'h7, RESP_OKAY);
    wr(OFS_CONV_CTRL, 32'h0, RESP_OKAY);
    settle();
    chk(34'(conv_ctl.gain_sel), 34'(3'b011));
    // Differential input runs with the buffer off.
    wr(OFS_CONFIG, 32'hb, RESP_OKAY);
    settle();
    chk(34'({conv_ctl.buf_on, conv_ctl.diff}), 34'h1);
    wr(OFS_CONFIG, 32'h6, RESP_OKAY);
    d = 12'($random(seed));
    wr(OFS_CONV_CTRL, 32'h1, RESP_OKAY);
    rd(OFS_CONV_CTRL, 32'h1, RESP_OKAY);
    chk(34'(conv_ctl.run), 34'h1);
    chk(34'(start_cnt), 34'h1);
    pulse(1'b1, 1'b0, d);
    rd(OFS_CONV_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_RESULT, 32'(d), RESP_OKAY);
    rd(OFS_FLAG, 32'h80, RESP_OKAY);
    rd(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
    wr(OFS_CONV_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_FLAG, 32'h0, RESP_OKAY);
    // A completion while idle must leave the last result alone.
    pulse(1'b1, 1'b0, ~d);
    rd(OFS_RESULT, 32'(d), RESP_OKAY);
    chk(34'(irq), 34'h0);
    wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
    settle();
    chk(34'(irq), 34'h1);
    wr(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
    settle();
    chk(34'(irq), 34'h0);
    rd(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
    // Continuous mode keeps running past a completion until the DMA sequence ends.
    d = 12'($random(seed));
    wr(OFS_CONFIG, 32'h16, RESP_OKAY);
    wr(OFS_CONV_CTRL, 32'h1, RESP_OKAY);
    pulse(1'b1, 1'b0, d);
    rd(OFS_CONV_CTRL, 32'h1, RESP_OKAY);
    rd(OFS_RESULT, 32'(d), RESP_OKAY);
    pulse(1'b0, 1'b1, 12'h0);
    rd(OFS_CONV_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_IRQ_STAT, 32'h3, RESP_OKAY);
    settle();
    chk(34'(irq), 34'h1);
    wr(OFS_IRQ_STAT, 32'h3, RESP_OKAY);
    wr(OFS_CONV_CTRL, 32'h1, RESP_OKAY);
    wr(OFS_CONV_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_CONV_CTRL, 32'h0, RESP_OKAY);
    settle();
    chk(34'(conv_ctl.run), 34'h0);
    // A reset with the probe powered and the converter idle must switch the probe off and clear the result.
    wr(OFS_PROBE_CTRL, 32'h80, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_PROBE_CTRL, 32'h0, RESP_OKAY);
    rd(OFS_RESULT, 32'h0, RESP_OKAY);
    ce <= 1'b0;
    settle();
    chk(34'({awready, wready, arready}), 34'h0);
    ce <= 1'b1;
    settle();
    end_of_test();
  end
endmodule // adc_conversion_control_test

// *** adcc_axil.sv ***
// AXI4-Lite slave front end that turns bus transfers into register strobes.
`timescale 1ns/100ps
module adcc_axil import adcc_pkg::*; (
  // Clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // Read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Register side
  output adcc_wr_s wr,
  input wire logic wr_err,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_v_q;
  logic w_v_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Address and data are parked separately so they may arrive in either order.
  assign awready = ce && !aw_v_q && !bvalid;
  assign wready = ce && !w_v_q && !bvalid;
  assign arready = ce && !rvalid;
  assign rd_addr = araddr;
  assign wr.en = ce && aw_v_q && w_v_q && !bvalid;
  assign wr.addr = aw_addr_q;
  assign wr.data = w_data_q;
  assign wr.strb = w_strb_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_v_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr.en) begin
        aw_v_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_v_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (ce) begin
      if (wvalid && wready) begin
        w_v_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr.en) begin
        w_v_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr.en) begin
        bvalid <= 1'b1;
        bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_data;
        rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // adcc_axil

// *** adcc_gain.sv ***
// Gain selection former: joins the direction bit and the two low gain bits.
`timescale 1ns/100ps
module adcc_gain import adcc_pkg::*; (
  // Clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Gain fields
  input wire logic dir,
  input wire logic [1:0] code,
  // Formed selection and its gain as a power of two
  output logic [2:0] amp_gain_select,
  output logic [3:0] gain_exp
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      amp_gain_select <= {1'b0, GAIN_LO_RESET};
      gain_exp <= 4'h0;
    end else if (ce) begin
      amp_gain_select <= {dir, code};
      // Exponent is two's complement: -2 to 1 for attenuation, 1 to 4 for gain.
      gain_exp <= dir ? {2'h0, code} + EXP_HIGH_BIAS : {2'h0, code} - EXP_LOW_BIAS;
    end
  end

  property p_sel_form;
    @(posedge aclk) disable iff (!aresetn)
    ce |=> amp_gain_select == {$past(dir), $past(code)};
  endproperty
  a_sel_form: assert property (p_sel_form)
    else $error("Gain selection does not follow direction and code.");

  property p_gain_map;
    @(posedge aclk) disable iff (!aresetn)
    (ce && dir && code == 2'h3) |=> gain_exp == 4'h4;
  endproperty
  a_gain_map: assert property (p_gain_map)
    else $error("Highest gain code is not a gain of sixteen.");

  property p_gain_low;
    @(posedge aclk) disable iff (!aresetn)
    (ce && !dir && code == 2'h0) |=> gain_exp == 4'he;
  endproperty
  a_gain_low: assert property (p_gain_low)
    else $error("Lowest gain code is not a quarter.");
endmodule // adcc_gain

// *** adcc_pkg.sv ***
// Shared constants, register map and carrier types of the converter control block.
// What this block does
// - The start bit starts a conversion when set, reads one while converting, and stops on zero.
// - The start bit clears itself when a single conversion or a DMA sequence completes.
// - Bit 1 of the conversion control register is the top bit of the three-bit gain selection.
// - Bit 7 of the probe control register powers the thermal probe and resets to off.
// - The result register shows the 12-bit result read-only, with bits 31 to 12 at zero.
// - Direction zero gives gains 1/4, 1/2, 1, 2 and direction one gives 2, 4, 8, 16.
// - Any write to the conversion control register clears the conversion done flag, unless a conversion completes in that cycle.
package adcc_pkg;
  localparam int ADDR_W = 8;
  localparam int RESULT_W = 12;
  localparam logic [7:0] OFS_CONV_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROBE_CTRL = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_FLAG = 8'h18;
  localparam int GO_BIT = 0;
  localparam int GAIN_DIR_BIT = 1;
  localparam int PROBE_PWR_BIT = 7;
  localparam int DONE_FLAG_BIT = 7;
  localparam int CFG_GAIN_LSB = 0;
  localparam int CFG_BUF_BIT = 2;
  localparam int CFG_DIFF_BIT = 3;
  localparam int CFG_CONT_BIT = 4;
  localparam int IRQ_W = 2;
  localparam int IRQ_CONV_BIT = 0;
  localparam int IRQ_DMA_BIT = 1;
  localparam logic [1:0] GAIN_LO_RESET = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] EXP_LOW_BIAS = 4'h2;
  localparam logic [3:0] EXP_HIGH_BIAS = 4'h1;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } adcc_wr_s;

  typedef struct packed {
    logic run;
    logic start;
    logic [2:0] gain_sel;
    logic buf_on;
    logic diff;
    logic probe_pwr;
  } adcc_conv_s;

  // Registers take whole aligned words, so the two low address bits are ignored.
  function automatic logic adcc_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction
endpackage

// *** adcc_top.sv ***
// Conversion control block: start bit, gain, probe power, result and interrupt registers.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module adcc_top import adcc_pkg::*; (
  // Clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Converter core
  output adcc_conv_s conv_ctl,
  output logic [3:0] gain_exp,
  input wire logic conv_done,
  input wire logic [RESULT_W-1:0] conv_data,
  input wire logic dma_done,
  // Interrupt
  output logic irq
);
  adcc_wr_s wr;
  logic wr_err;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;

  logic go_q;
  logic start_q;
  logic dir_q;
  logic probe_pwr_q;
  logic [1:0] gain_lo_q;
  logic buf_on_q;
  logic diff_q;
  logic cont_q;
  logic [RESULT_W-1:0] result_q;
  logic done_flag_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] mask_q;
  logic [2:0] gain_sel;

  logic wr_conv;
  logic wr_conv_b0;
  logic wr_probe;
  logic wr_cfg;
  logic wr_stat;
  logic wr_mask;
  logic wr_go;
  logic wr_pwr;
  logic conv_fin;
  logic go_end;
  logic [IRQ_W-1:0] events;

  adcc_axil i_adcc_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr(wr),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  adcc_gain i_adcc_gain (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .dir(dir_q),
    .code(gain_lo_q),
    .amp_gain_select(gain_sel),
    .gain_exp(gain_exp)
  );

  // Any write to the control word counts, but fields change only with byte lane 0.
  assign wr_conv = wr.en && adcc_hit(wr.addr, OFS_CONV_CTRL);
  assign wr_conv_b0 = wr_conv && wr.strb[0];
  assign wr_probe = wr.en && wr.strb[0] && adcc_hit(wr.addr, OFS_PROBE_CTRL);
  assign wr_cfg = wr.en && wr.strb[0] && adcc_hit(wr.addr, OFS_CONFIG);
  assign wr_stat = wr.en && wr.strb[0] && adcc_hit(wr.addr, OFS_IRQ_STAT);
  assign wr_mask = wr.en && wr.strb[0] && adcc_hit(wr.addr, OFS_IRQ_MASK);
  assign wr_go = wr.data[GO_BIT];
  assign wr_pwr = wr.data[PROBE_PWR_BIT];
  // Results that arrive after software stopped the converter are dropped.
  assign conv_fin = conv_done && go_q;
  assign go_end = (conv_fin && !cont_q) || (go_q && dma_done);
  assign events = {go_q && dma_done, conv_fin};
  assign wr_err = !(adcc_hit(wr.addr, OFS_CONV_CTRL) || adcc_hit(wr.addr, OFS_PROBE_CTRL)
    || adcc_hit(wr.addr, OFS_RESULT) || adcc_hit(wr.addr, OFS_CONFIG)
    || adcc_hit(wr.addr, OFS_IRQ_STAT) || adcc_hit(wr.addr, OFS_IRQ_MASK)
    || adcc_hit(wr.addr, OFS_FLAG));

  // A software write beats a same-cycle completion so a fresh start is never lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go_q <= 1'b0;
    end else if (ce) begin
      if (wr_conv_b0) begin
        go_q <= wr_go;
      end else if (go_end) begin
        go_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
    end else if (ce) begin
      start_q <= wr_conv_b0 && wr_go && !go_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_q <= 1'b0;
    end else if (ce && wr_conv_b0) begin
      dir_q <= wr.data[GAIN_DIR_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      probe_pwr_q <= 1'b0;
    end else if (ce && wr_probe) begin
      probe_pwr_q <= wr_pwr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_lo_q <= GAIN_LO_RESET;
      buf_on_q <= 1'b0;
      diff_q <= 1'b0;
      cont_q <= 1'b0;
    end else if (ce && wr_cfg) begin
      gain_lo_q <= wr.data[CFG_GAIN_LSB +: 2];
      buf_on_q <= wr.data[CFG_BUF_BIT];
      diff_q <= wr.data[CFG_DIFF_BIT];
      cont_q <= wr.data[CFG_CONT_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= '0;
    end else if (ce && conv_fin) begin
      result_q <= conv_data;
    end
  end

  // The done flag is set by hardware; a completion in the clearing cycle still sets it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag_q <= 1'b0;
    end else if (ce) begin
      if (conv_fin) begin
        done_flag_q <= 1'b1;
      end else if (wr_conv) begin
        done_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= '0;
    end else if (ce) begin
      stat_q <= (stat_q & ~(wr_stat ? wr.data[IRQ_W-1:0] : '0)) | events;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q <= '0;
    end else if (ce && wr_mask) begin
      mask_q <= wr.data[IRQ_W-1:0];
    end
  end

  assign irq = |(stat_q & mask_q);
  assign conv_ctl.run = go_q;
  assign conv_ctl.start = start_q;
  assign conv_ctl.gain_sel = gain_sel;
  assign conv_ctl.buf_on = buf_on_q;
  assign conv_ctl.diff = diff_q;
  assign conv_ctl.probe_pwr = probe_pwr_q;

  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (adcc_hit(rd_addr, OFS_CONV_CTRL)) begin
      rd_data[GO_BIT] = go_q;
      rd_data[GAIN_DIR_BIT] = dir_q;
    end else if (adcc_hit(rd_addr, OFS_PROBE_CTRL)) begin
      rd_data[PROBE_PWR_BIT] = probe_pwr_q;
    end else if (adcc_hit(rd_addr, OFS_RESULT)) begin
      rd_data[RESULT_W-1:0] = result_q;
    end else if (adcc_hit(rd_addr, OFS_CONFIG)) begin
      rd_data[CFG_GAIN_LSB +: 2] = gain_lo_q;
      rd_data[CFG_BUF_BIT] = buf_on_q;
      rd_data[CFG_DIFF_BIT] = diff_q;
      rd_data[CFG_CONT_BIT] = cont_q;
    end else if (adcc_hit(rd_addr, OFS_IRQ_STAT)) begin
      rd_data[IRQ_W-1:0] = stat_q;
    end else if (adcc_hit(rd_addr, OFS_IRQ_MASK)) begin
      rd_data[IRQ_W-1:0] = mask_q;
    end else if (adcc_hit(rd_addr, OFS_FLAG)) begin
      rd_data[DONE_FLAG_BIT] = done_flag_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  property p_go_write;
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_conv_b0) |=> go_q == $past(wr_go);
  endproperty
  a_go_write: assert property (p_go_write)
    else $error("Start bit does not take the written value.");

  property p_go_end;
    @(posedge aclk) disable iff (!aresetn)
    (ce && !wr_conv_b0 && go_q && ((conv_done && !cont_q) || dma_done)) |=> !go_q;
  endproperty
  a_go_end: assert property (p_go_end)
    else $error("Start bit stays set after its conversion ended.");

  property p_probe_pwr;
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_probe) |=> conv_ctl.probe_pwr == $past(wr_pwr);
  endproperty
  a_probe_pwr: assert property (p_probe_pwr)
    else $error("Probe power does not follow its control bit.");

  property p_result_read;
    @(posedge aclk) disable iff (!aresetn)
    (ce && arvalid && arready && adcc_hit(araddr, OFS_RESULT))
      |=> rvalid && rdata == {20'h0, $past(result_q)};
  endproperty
  a_result_read: assert property (p_result_read)
    else $error("Result read does not show the held value with zero upper bits.");

  property p_flag_clear;
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_conv && !conv_fin) |=> !done_flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("Done flag survives a control register write.");

  property p_result_hold;
    @(posedge aclk) disable iff (!aresetn)
    (ce && conv_fin) |=> result_q == $past(conv_data);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("Result register does not capture the finished conversion.");

  property p_result_keep;
    @(posedge aclk) disable iff (!aresetn)
    !(ce && conv_fin) |=> $stable(result_q);
  endproperty
  a_result_keep: assert property (p_result_keep)
    else $error("Result register changes without a finished conversion.");

  property p_start_pulse;
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_conv_b0 && wr_go && !go_q) |=> conv_ctl.start && go_q;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("Setting the start bit gives no start pulse.");

  property p_done_set;
    @(posedge aclk) disable iff (!aresetn)
    (ce && conv_fin) |=> done_flag_q && stat_q[IRQ_CONV_BIT];
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("Finished conversion does not raise the done flag and status.");
endmodule // adcc_top
